/* src/trig_select.sv */
// Trigger source selection, masking and priority dispatch of the state engine.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "trig_map.svh"

module trig_select import trig_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [`GPIO_COUNT-1:0] GPIO_IN,
  input wire logic ON_REQ,
  input wire logic WAIT_TIMEOUT,
  input wire logic SEQ_END,
  input wire logic MASK_LOAD,
  input wire logic [`TRIG_COUNT-1:0] MASK_VAL,
  input wire logic [1:0] STATE_ARRIVE,
  output logic SEQ_START,
  output logic SEQ_PREEMPT,
  output logic [`TRIG_ID_W-1:0] SEQ_ID,
  output logic [1:0] CUR_STATE,
  output logic [3:0] RAIL_EN,
  output logic [`GPIO_COUNT-1:0] GPO_OUT,
  output logic [7:0] STEP_DELAY,
  output logic IRQ
);

  // ****************************************************************
  // Reset release and input synchronisers
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [`GPIO_COUNT:0] pin_meta_q;
  logic [`GPIO_COUNT:0] pin_sync_q;
  logic on_req_prev_q;

  // The reset is asserted at once and released through two flops.
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Pins are asynchronous; only the second stage is read by logic.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      on_req_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= {ON_REQ, GPIO_IN};
      pin_sync_q <= pin_meta_q;
      on_req_prev_q <= pin_sync_q[`GPIO_COUNT];
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic [1:0] dest_q;
  logic [7:0] sw_trig_q;
  logic [7:0] scratch_q;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_mask_q;
  logic [21:0] state_cfg_q [4];
  logic [`IRQ_W-1:0] irq_set;
  logic wr_cfg;

  assign wr_cfg = WR && (ADDR >= `OFS_TRIG_CFG) && (ADDR <= `OFS_TRIG_CFG_END);

  // Plain control registers written by software.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dest_q <= `CTRL_RST;
      sw_trig_q <= 8'h00;
      scratch_q <= 8'h00;
      irq_mask_q <= '0;
    end else if (WR) begin
      if (ADDR == `OFS_CTRL) begin
        dest_q <= WDATA[1:0];
      end else if (ADDR == `OFS_SW_TRIG) begin
        sw_trig_q <= WDATA[7:0];
      end else if (ADDR == `OFS_SCRATCH) begin
        scratch_q <= WDATA[7:0];
      end else if (ADDR == `OFS_IRQ_MASK) begin
        irq_mask_q <= WDATA[`IRQ_W-1:0];
      end
    end
  end

  // per-state outputs: rails [3:0], outputs [13:4], delay [21:14].
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        state_cfg_q[i] <= 22'h000000;
      end
    end else if (WR && (ADDR[7:4] == 4'h2) && (ADDR[1:0] == 2'h0)) begin
      state_cfg_q[ADDR[3:2]] <= WDATA[21:0];
    end
  end

  // Sticky event bits; a new event wins over a write-one clear.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else if (WR && (ADDR == `OFS_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~WDATA[`IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end
  assign IRQ = |(irq_stat_q & irq_mask_q);

  // ****************************************************************
  // Trigger sources
  // ****************************************************************
  logic su_std_q;
  logic su_alt_q;
  logic wait_q;
  logic on_req_rise;
  logic [31:0] src_vec;

  assign on_req_rise = pin_sync_q[`GPIO_COUNT] && !on_req_prev_q;

  // Startup and timeout events are held until the next state is reached,
  // so that the slow scan of the slot table cannot miss a short pulse.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      su_std_q <= 1'b0;
      su_alt_q <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      su_std_q <= (su_std_q && !MASK_LOAD) || (on_req_rise && (dest_q == `DEST_STANDBY));
      su_alt_q <= (su_alt_q && !MASK_LOAD) || (on_req_rise && (dest_q == `DEST_ALT));
      wait_q <= (wait_q && !MASK_LOAD) || WAIT_TIMEOUT;
    end
  end

  // pin sources, software bits, scratch bits.
  // constant sources at numbers zero and one.
  assign src_vec = {1'b0, scratch_q, sw_trig_q, pin_sync_q[`GPIO_COUNT-1:0],
                    wait_q, su_alt_q, su_std_q, 1'b1, 1'b0};

  // ****************************************************************
  // Slot scan
  // ****************************************************************
  cfg_mem_if cfg_bus ();
  cfg_table u_cfg_table (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .port(cfg_bus.mem)
  );

  logic [`TRIG_ID_W-1:0] scan_q;
  logic [`TRIG_ID_W-1:0] slot_q;
  logic [`TRIG_COUNT-1:0] prev_lvl_q;
  logic [`TRIG_COUNT-1:0] pend_q;
  logic [`TRIG_COUNT-1:0] imm_q;
  logic [`TRIG_COUNT-1:0] mask_q;
  logic cur_lvl;
  logic hit;
  trig_type_t cfg_type;

  assign cfg_bus.wr_en = wr_cfg;
  assign cfg_bus.wr_addr = 5'((ADDR - `OFS_TRIG_CFG) >> 2);
  assign cfg_bus.wr_data = WDATA[7:0];
  assign cfg_bus.rd_addr = scan_q;

  // One slot is read per cycle; the word returns with the slot number.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      scan_q <= '0;
      slot_q <= '0;
    end else begin
      scan_q <= (scan_q == 5'(`TRIG_COUNT - 1)) ? 5'h00 : scan_q + 5'h01;
      slot_q <= scan_q;
    end
  end

  assign cur_lvl = src_vec[cfg_bus.rd_data[`CFG_TYPE_LSB-1:`CFG_SRC_LSB]];
  assign cfg_type = trig_type_t'(cfg_bus.rd_data[`CFG_IMM_BIT-1:`CFG_TYPE_LSB]);

  // sensitivity: edges compare against this slot's previous sample.
  always_comb begin
    case (cfg_type)
      TYPE_HIGH: hit = cur_lvl;
      TYPE_LOW: hit = !cur_lvl;
      TYPE_RISE: hit = cur_lvl && !prev_lvl_q[slot_q];
      default: hit = !cur_lvl && prev_lvl_q[slot_q];
    endcase
  end

  // Level history and immediate flag of each slot.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      prev_lvl_q <= '0;
      imm_q <= '0;
    end else begin
      prev_lvl_q[slot_q] <= cur_lvl;
      imm_q[slot_q] <= cfg_bus.rd_data[`CFG_IMM_BIT];
    end
  end

  // whole mask replaced by one command.
  // mask applied on arriving in a state.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= `MASK_RST;
    end else if (MASK_LOAD) begin
      mask_q <= MASK_VAL;
    end
  end

  // ****************************************************************
  // Priority dispatch
  // ****************************************************************
  // Lowest set bit wins; returns found flag and trigger number.
  function automatic logic [`TRIG_ID_W:0] first_set(input logic [`TRIG_COUNT-1:0] v);
    logic [`TRIG_ID_W:0] r;
    r = '0;
    for (int i = `TRIG_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction : first_set

  eng_state_t eng_q;
  logic [`TRIG_COUNT-1:0] ready_v;
  logic [`TRIG_ID_W:0] pick_any;
  logic [`TRIG_ID_W:0] pick_imm;
  logic take;
  logic take_imm;
  logic [`TRIG_ID_W-1:0] take_id;

  // a set mask bit keeps a pending trigger from being served.
  assign ready_v = pend_q & ~mask_q;
  // rank follows the ID, so destination priority is set by ID order.
  assign pick_any = first_set(ready_v);
  // immediate candidates may cut into a running sequence.
  assign pick_imm = first_set(ready_v & imm_q);

  // normal triggers only start from idle, after the sequence end.
  // only a selected, pending slot can start a transition.
  always_comb begin
    take = 1'b0;
    take_imm = 1'b0;
    take_id = '0;
    case (eng_q)
      ENG_IDLE: begin
        take = pick_any[`TRIG_ID_W];
        take_id = pick_any[`TRIG_ID_W-1:0];
      end
      default: begin
        take = pick_imm[`TRIG_ID_W];
        take_imm = pick_imm[`TRIG_ID_W];
        take_id = pick_imm[`TRIG_ID_W-1:0];
      end
    endcase
  end

  // Pending bits; a fresh hit in the served cycle is kept.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else begin
      for (int i = 0; i < `TRIG_COUNT; i++) begin
        if (hit && (slot_q == 5'(i))) begin
          pend_q[i] <= 1'b1;
        end else if (take && (take_id == 5'(i))) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // Engine state: busy from a start until the sequence reports its end.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      eng_q <= ENG_IDLE;
    end else begin
      case (eng_q)
        ENG_IDLE: begin
          if (take) begin
            eng_q <= ENG_RUN;
          end
        end
        default: begin
          if (SEQ_END && !take) begin
            eng_q <= ENG_IDLE;
          end
        end
      endcase
    end
  end

  // Start request towards the command datapath, held one cycle.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      SEQ_START <= 1'b0;
      SEQ_PREEMPT <= 1'b0;
      SEQ_ID <= '0;
    end else begin
      SEQ_START <= take;
      SEQ_PREEMPT <= take_imm;
      if (take) begin
        SEQ_ID <= take_id;
      end
    end
  end
  assign irq_set = {SEQ_PREEMPT, SEQ_START};

  // ****************************************************************
  // Power state outputs
  // ****************************************************************
  // state code is its rank; ACTIVE is code zero.
  // rails, outputs and delay follow the state reached.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CUR_STATE <= PS_STANDBY;
      RAIL_EN <= 4'h0;
      GPO_OUT <= '0;
      STEP_DELAY <= 8'h00;
    end else if (MASK_LOAD) begin
      CUR_STATE <= STATE_ARRIVE;
      RAIL_EN <= state_cfg_q[STATE_ARRIVE][3:0];
      GPO_OUT <= state_cfg_q[STATE_ARRIVE][13:4];
      STEP_DELAY <= state_cfg_q[STATE_ARRIVE][21:14];
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Data stand in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 32'h00000000;
    end else if (!RD) begin
      RDATA <= 32'h00000000;
    end else if (ADDR == `OFS_CTRL) begin
      RDATA <= {30'h0, dest_q};
    end else if (ADDR == `OFS_SW_TRIG) begin
      RDATA <= {24'h0, sw_trig_q};
    end else if (ADDR == `OFS_SCRATCH) begin
      RDATA <= {24'h0, scratch_q};
    end else if (ADDR == `OFS_MASK) begin
      RDATA <= {4'h0, mask_q};
    end else if (ADDR == `OFS_STATUS) begin
      RDATA <= {21'h0, SEQ_ID, CUR_STATE, eng_q == ENG_RUN, |ready_v, |pend_q, 1'b0};
    end else if (ADDR == `OFS_IRQ_STAT) begin
      RDATA <= {30'h0, irq_stat_q};
    end else if (ADDR == `OFS_IRQ_MASK) begin
      RDATA <= {30'h0, irq_mask_q};
    end else if ((ADDR[7:4] == 4'h2) && (ADDR[1:0] == 2'h0)) begin
      RDATA <= {10'h0, state_cfg_q[ADDR[3:2]]};
    end else begin
      RDATA <= 32'h00000000;
    end
  end

endmodule : trig_select

/* common/trig_map.svh */
// Register offsets, field positions, reset values and counts of the trigger selector.
`ifndef TRIG_MAP_SVH
`define TRIG_MAP_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define TRIG_COUNT 28
`define TRIG_ID_W 5
`define SRC_W 5
`define CFG_W 8
`define GPIO_COUNT 10

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_CTRL 8'h00
`define OFS_SW_TRIG 8'h04
`define OFS_SCRATCH 8'h08
`define OFS_MASK 8'h0C
`define OFS_STATUS 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_STATE_CFG 8'h20
`define OFS_TRIG_CFG 8'h40
`define OFS_TRIG_CFG_END 8'hAC

// ****************************************************************
// Trigger config word fields
// ****************************************************************
`define CFG_SRC_LSB 0
`define CFG_TYPE_LSB 5
`define CFG_IMM_BIT 7

// ****************************************************************
// Trigger source numbers
// ****************************************************************
`define SRC_ZERO 0
`define SRC_ONE 1
`define SRC_STARTUP_TO_STANDBY_TRIGGER 2
`define SRC_SU_ALT 3
`define SRC_WAIT 4
`define SRC_GPIO0 5
`define SRC_SW0 15
`define SRC_SCRATCH0 23

// ****************************************************************
// Startup destination codes, reset values and interrupt bit positions
// ****************************************************************
`define DEST_STANDBY 2'h0
`define DEST_ALT 2'h1
`define MASK_RST 28'h0000000
`define CTRL_RST 2'h0
`define IRQ_SERVICED 0
`define IRQ_PREEMPT 1
`define IRQ_W 2

`endif

/* common/trig_pkg.sv */
// Types shared by the trigger selector and its configuration table.
package trig_pkg;

  // Sensitivity of one trigger.
  typedef enum logic [1:0] {
    TYPE_HIGH = 2'h0,
    TYPE_LOW = 2'h1,
    TYPE_RISE = 2'h2,
    TYPE_FALL = 2'h3
  } trig_type_t;

  // Dispatch engine states, one-hot.
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_RUN = 2'b10
  } eng_state_t;

  // Power states, code equals priority rank (0 is highest).
  typedef enum logic [1:0] {
    PS_ACTIVE = 2'h0,
    PS_MCU_ONLY = 2'h1,
    PS_DEEP_SLEEP = 2'h2,
    PS_STANDBY = 2'h3
  } pwr_state_t;

endpackage : trig_pkg

/* common/cfg_mem_if.sv */
// Interface between the selector and its trigger configuration table.
`timescale 1ns/1ps
interface cfg_mem_if;
  logic wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : cfg_mem_if

/* src/cfg_table.sv */
// Small memory holding one configuration word per trigger slot.
`timescale 1ns/1ps
`include "trig_map.svh"
module cfg_table import trig_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  cfg_mem_if.mem port
);

  logic [`CFG_W-1:0] mem_q [`TRIG_COUNT];

  // Write port; slots beyond the table are ignored.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `TRIG_COUNT; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (port.wr_en && (port.wr_addr < 5'(`TRIG_COUNT))) begin
      mem_q[port.wr_addr] <= port.wr_data;
    end
  end

  // Registered read port; data appear one cycle after the address.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port.rd_data <= 8'h00;
    end else if (port.rd_addr < 5'(`TRIG_COUNT)) begin
      port.rd_data <= mem_q[port.rd_addr];
    end else begin
      port.rd_data <= 8'h00;
    end
  end

endmodule : cfg_table

/* tb/trig_select_monitor.sv */
// Port-level assertions for the trigger selector.
`timescale 1ns/1ps
`include "trig_map.svh"
module trig_select_monitor (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic SEQ_END,
  input wire logic MASK_LOAD,
  input wire logic [`TRIG_COUNT-1:0] MASK_VAL,
  input wire logic [1:0] STATE_ARRIVE,
  input wire logic SEQ_START,
  input wire logic SEQ_PREEMPT,
  input wire logic [`TRIG_ID_W-1:0] SEQ_ID,
  input wire logic [1:0] CUR_STATE,
  input wire logic [3:0] RAIL_EN,
  input wire logic [`GPIO_COUNT-1:0] GPO_OUT,
  input wire logic [7:0] STEP_DELAY,
  input wire logic IRQ
);
  logic [`TRIG_COUNT-1:0] msk_q;
  logic [`TRIG_COUNT-1:0] msk1_q;
  logic busy_q;

  // Shadow of the loaded mask; the copy one cycle older is the one that a
  // start pulse was chosen against, since the start is registered.
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      msk_q <= `MASK_RST;
      msk1_q <= `MASK_RST;
    end else begin
      msk_q <= MASK_LOAD ? MASK_VAL : msk_q;
      msk1_q <= msk_q;
    end
  end

  // A sequence runs from its start pulse until the end command.
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= SEQ_START ? 1'b1 : (SEQ_END ? 1'b0 : busy_q);
    end
  end

  // ********
  // Checks
  // ********
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  a_preempt_pairs: assert property (SEQ_PREEMPT |-> SEQ_START)
    else $error("preempt pulse without start");
  a_start_idle: assert property (SEQ_START && !SEQ_PREEMPT |-> !busy_q)
    else $error("normal start while busy");
  a_masked_quiet: assert property (SEQ_START |-> !msk1_q[SEQ_ID])
    else $error("masked trigger started");
  a_id_holds: assert property (!SEQ_START |-> $stable(SEQ_ID))
    else $error("trigger id moved without start");
  a_state_follows: assert property (MASK_LOAD |=> CUR_STATE == $past(STATE_ARRIVE))
    else $error("state not taken on mask load");
  a_outs_on_load: assert property ($changed({CUR_STATE, RAIL_EN, GPO_OUT, STEP_DELAY})
    |-> $past(MASK_LOAD)) else $error("state outputs moved without mask load");
  a_mask_readback: assert property ($past(RD) && $past(ADDR) == `OFS_MASK
    |-> RDATA == {4'h0, $past(msk_q)}) else $error("mask readback wrong");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside read cycle");
  a_irq_rise: assert property ($rose(IRQ) |-> $past(SEQ_START) || $past(SEQ_START, 2) || $past(WR))
    else $error("interrupt without cause");
  a_irq_fall: assert property ($fell(IRQ) |-> $past(WR))
    else $error("interrupt dropped without write");

  c_preempt: cover property (SEQ_PREEMPT);
  c_load_end: cover property (MASK_LOAD ##1 SEQ_END);
  c_irq: cover property ($rose(IRQ));
endmodule : trig_select_monitor

bind trig_select trig_select_monitor trig_select_monitor_i (.CORE_CLK(CORE_CLK), .NRST(NRST),
  .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .SEQ_END(SEQ_END), .MASK_LOAD(MASK_LOAD),
  .MASK_VAL(MASK_VAL), .STATE_ARRIVE(STATE_ARRIVE), .SEQ_START(SEQ_START),
  .SEQ_PREEMPT(SEQ_PREEMPT), .SEQ_ID(SEQ_ID), .CUR_STATE(CUR_STATE), .RAIL_EN(RAIL_EN),
  .GPO_OUT(GPO_OUT), .STEP_DELAY(STEP_DELAY), .IRQ(IRQ));

/* tb/seq_datapath_model.sv */
// Behavioural command datapath that answers each started sequence.
`timescale 1ns/1ps
module seq_datapath_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic seq_start,
  input wire logic [7:0] lat,
  input wire logic [27:0] mask_in,
  input wire logic [1:0] state_in,
  output logic mask_load,
  output logic [27:0] mask_val,
  output logic [1:0] state_arrive,
  output logic seq_end
);
  logic [7:0] cnt_q;
  logic run_q;

  // Any start, a pre-empting one too, restarts the countdown like a branch.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (seq_start) begin
      run_q <= 1'b1;
      cnt_q <= lat;
    end else if (run_q) begin
      cnt_q <= cnt_q - 8'h01;
      run_q <= (cnt_q != 8'h00);
    end
  end

  // Idle data is inverted so a stale value never passes for a load.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_load <= 1'b0;
      seq_end <= 1'b0;
      mask_val <= 28'h0000000;
      state_arrive <= 2'h0;
    end else begin
      mask_load <= run_q && !seq_start && cnt_q == 8'h02;
      mask_val <= (run_q && cnt_q == 8'h02) ? mask_in : ~mask_in;
      state_arrive <= (run_q && cnt_q == 8'h02) ? state_in : ~state_in;
      seq_end <= run_q && !seq_start && cnt_q == 8'h01;
    end
  end
endmodule : seq_datapath_model

/* tb/trig_select_tb.sv */
// Self-checking bench of the trigger selector with a datapath model.
`timescale 1ns/1ps
`include "trig_map.svh"
module trig_select_tb;
  import trig_pkg::*;
  logic CORE_CLK = 1'b0;
  logic NRST = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [9:0] GPIO_IN = 10'h000;
  logic ON_REQ = 1'b0;
  logic WAIT_TIMEOUT = 1'b0;
  logic [31:0] RDATA;
  logic SEQ_END, MASK_LOAD, SEQ_START, SEQ_PREEMPT, IRQ;
  logic [27:0] MASK_VAL;
  logic [1:0] STATE_ARRIVE, CUR_STATE;
  logic [4:0] SEQ_ID;
  logic [3:0] RAIL_EN;
  logic [9:0] GPO_OUT;
  logic [7:0] STEP_DELAY;
  logic [7:0] lat = 8'h08;
  logic [27:0] mask_in = 28'h0000000;
  logic [1:0] state_in = 2'h2;
  int errors = 0;
  int n_compared = 0;
  int s;

  trig_select trig_select_i (.CORE_CLK(CORE_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .GPIO_IN(GPIO_IN), .ON_REQ(ON_REQ),
    .WAIT_TIMEOUT(WAIT_TIMEOUT), .SEQ_END(SEQ_END), .MASK_LOAD(MASK_LOAD), .MASK_VAL(MASK_VAL),
    .STATE_ARRIVE(STATE_ARRIVE), .SEQ_START(SEQ_START), .SEQ_PREEMPT(SEQ_PREEMPT),
    .SEQ_ID(SEQ_ID), .CUR_STATE(CUR_STATE), .RAIL_EN(RAIL_EN), .GPO_OUT(GPO_OUT),
    .STEP_DELAY(STEP_DELAY), .IRQ(IRQ));
  seq_datapath_model seq_datapath_model_i (.clk(CORE_CLK), .rst_n(NRST), .seq_start(SEQ_START),
    .lat(lat), .mask_in(mask_in), .state_in(state_in), .mask_load(MASK_LOAD),
    .mask_val(MASK_VAL), .state_arrive(STATE_ARRIVE), .seq_end(SEQ_END));

  // Free-running core clock.
  always #5 CORE_CLK = ~CORE_CLK;

  // ********
  // Tasks
  // ********
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task close_out;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1;
    chk(nm, RDATA, exp);
  endtask : rd

  // Bounded wait for a start pulse or the model's end command.
  task automatic wait_ev(input bit for_end);
    int i;
    i = 0;
    do begin
      @(posedge CORE_CLK);
      #1;
      i++;
    end while ((for_end ? SEQ_END : SEQ_START) !== 1'b1 && i < 300);
    if ((for_end ? SEQ_END : SEQ_START) !== 1'b1) begin
      errors++;
      $display("mismatch wait_event expected %0d seen timeout", for_end);
      close_out();
    end
  endtask : wait_ev

  task start_is(input int id, input logic pre);
    wait_ev(1'b0);
    chk("seq_id", SEQ_ID, id);
    chk("seq_preempt", SEQ_PREEMPT, pre);
  endtask : start_is

  task cfg(input int slot, input int src, input logic imm, input trig_type_t typ);
    wr(8'(`OFS_TRIG_CFG + 4 * slot), {imm, typ, 5'(src)});
  endtask : cfg

  // Drives the level behind one source number; sticky events need only a pulse.
  task stim(input int src, input logic v);
    if (src < 4) begin
      if (v) wr(`OFS_CTRL, src - 2);
      @(posedge CORE_CLK) ON_REQ <= v;
    end else if (src == 4) begin
      @(posedge CORE_CLK) WAIT_TIMEOUT <= v;
      @(posedge CORE_CLK) WAIT_TIMEOUT <= 1'b0;
    end else if (src < 15) begin
      @(posedge CORE_CLK) GPIO_IN[src-5] <= v;
    end else if (src < 23) wr(`OFS_SW_TRIG, 32'(v) << (src - 15));
    else wr(`OFS_SCRATCH, 32'(v) << (src - 23));
  endtask : stim

  // ********
  // Sequence
  // ********
  initial begin
    repeat (6) @(posedge CORE_CLK);
    NRST <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    chk("cur_state", CUR_STATE, 2'h3);
    wr(`OFS_STATE_CFG + 8'h08, {10'h0, 8'h5A, 10'h2C3, 4'h9});
    rd(`OFS_STATE_CFG + 8'h08, 32'h0016AC39, "state_cfg");
    rd(8'hFC, 32'h0, "unmapped");
    rd(`OFS_TRIG_CFG, 32'h0, "cfg_read");
    for (s = 2; s <= 30; s++) begin
      cfg(s % 28, s, 1'b0, TYPE_RISE);
      repeat (60) @(posedge CORE_CLK);
      stim(s, 1'b1);
      start_is(s % 28, 1'b0);
      stim(s, 1'b0);
      wait_ev(1'b1);
      repeat (70) @(posedge CORE_CLK);
    end
    chk("state_out", {CUR_STATE, RAIL_EN, GPO_OUT, STEP_DELAY}, {2'h2, 4'h9, 10'h2C3, 8'h5A});
    $display("test sources done");
    cfg(7, 7, 1'b0, TYPE_FALL);
    @(posedge CORE_CLK) GPIO_IN[2] <= 1'b1;
    repeat (60) @(posedge CORE_CLK);
    GPIO_IN[2] <= 1'b0;
    start_is(7, 1'b0);
    wait_ev(1'b1);
    cfg(25, 18, 1'b0, TYPE_RISE);
    repeat (60) @(posedge CORE_CLK);
    wr(`OFS_SW_TRIG, 32'h8);
    start_is(18, 1'b0);
    mask_in <= 28'h1 << 18;
    start_is(25, 1'b0);
    wait_ev(1'b1);
    wr(`OFS_SW_TRIG, 32'h0);
    repeat (60) @(posedge CORE_CLK);
    wr(`OFS_SW_TRIG, 32'h8);
    start_is(25, 1'b0);
    rd(`OFS_MASK, 32'h1 << 18, "mask_reg");
    mask_in <= 28'h0;
    start_is(18, 1'b0);
    wait_ev(1'b1);
    $display("test priority done");
    lat <= 8'h3C;
    // Slot 26 shares scratch bit 5 with slot 0 but may cut in while busy.
    cfg(26, 28, 1'b1, TYPE_RISE);
    wr(`OFS_IRQ_MASK, 32'h2);
    #1 chk("irq", IRQ, 1'b0);
    wr(`OFS_SCRATCH, 32'h10);
    start_is(27, 1'b0);
    wr(`OFS_SCRATCH, 32'h30);
    start_is(26, 1'b1);
    lat <= 8'h08;
    wait_ev(1'b1);
    start_is(0, 1'b0);
    wait_ev(1'b1);
    chk("irq", IRQ, 1'b1);
    rd(`OFS_IRQ_STAT, 32'h3, "irq_stat");
    wr(`OFS_IRQ_STAT, 32'h1);
    #1 chk("irq", IRQ, 1'b1);
    wr(`OFS_IRQ_STAT, 32'h2);
    #1 chk("irq", IRQ, 1'b0);
    rd(`OFS_STATUS, 32'h20, "status");
    $display("test preempt done");
    // Low level on scratch bit 4: the falling bit starts slot 3.
    cfg(3, 27, 1'b0, TYPE_LOW);
    repeat (60) @(posedge CORE_CLK);
    wr(`OFS_SCRATCH, 32'h20);
    start_is(3, 1'b0);
    cfg(3, 0, 1'b0, TYPE_HIGH);
    wait_ev(1'b1);
    cfg(1, 1, 1'b0, TYPE_HIGH);
    start_is(1, 1'b0);
    wait_ev(1'b1);
    start_is(1, 1'b0);
    $display("test constant done");
    close_out();
  end
endmodule : trig_select_tb
